// ### rtl/uhrp_params.svh
// Purpose: constants of the serial host register port
// Assumes: 25 MHz system clock
// Notes:   divider counts in reference-clock ticks
`ifndef UHRP_PARAMS_SVH
`define UHRP_PARAMS_SVH
`define UHRP_CLK_HZ          25000000
`define UHRP_REF_HZ          27120000
`define UHRP_BAUD_RESET      8'hEB
`define UHRP_EXP_MSB         7
`define UHRP_EXP_LSB         5
`define UHRP_MAN_MSB         4
`define UHRP_MAN_LSB         0
`define UHRP_MAN_OFFSET      17'h00021
`define UHRP_CMD_READ_BIT    7
`define UHRP_ADDR_MSB        5
`define UHRP_ADDR_BAUD       6'h00
`define UHRP_ADDR_TESTPIN    6'h01
`define UHRP_LINE_EN_BIT     7
`define UHRP_TESTPIN_RESET   8'h80
`define UHRP_OVS             16
`define UHRP_OVS_HALF        4'h7
`define UHRP_OVS_LAST        4'hF
`define UHRP_BITS_LAST       4'h9
`define UHRP_FIFO_DEPTH      4
`endif

// ### rtl/uhrp_pkg.sv
// Purpose: types of the serial host register port
// Assumes: included constants header
// Notes:   none
package uhrp_pkg;
   typedef struct packed {
      logic       rd;
      logic       rsvd;
      logic [5:0] addr;
   } uhrp_cmd_t;
   typedef enum logic [3:0] {
      UHRP_IDLE = 4'h1,
      UHRP_WDAT = 4'h2,
      UHRP_RESP = 4'h4,
      UHRP_WAIT = 4'h8
   } uhrp_state_t;
endpackage

// ### rtl/uhrp_fifo.sv
// Purpose: small valid/ready FIFO on the transmit path
// Assumes: single clock
// Notes:   depth power of two
`timescale 1ns/1ps
module uhrp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      count;
   assign count     = wr_ptr - rd_ptr;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr <= '0;
      end else if (in_valid && in_ready) begin
         wr_ptr <= wr_ptr + (AW+1)'(1);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_ptr <= '0;
      end else if (out_valid && out_ready) begin
         rd_ptr <= rd_ptr + (AW+1)'(1);
      end
   end
endmodule

// ### rtl/uhrp_top.sv
// Purpose: serial host port reading and writing device registers
// Assumes: rx pin asynchronous to clk_sys; 25 MHz clock
// Notes:   16x oversampling tick from a fractional accumulator
`timescale 1ns/1ps
`include "uhrp_params.svh"
module uhrp_top
   import uhrp_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Serial link
   input  wire logic rx,
   output logic      tx,
   // Auxiliary lines, enable low while driven
   output logic      data_request_line,
   output logic      data_request_line_oe_n,
   output logic      multiplex_line,
   output logic      multiplex_line_oe_n,
   input  wire logic data_request_in,
   // Device register side
   output logic       reg_rd,
   output logic       reg_wr,
   output logic [5:0] reg_addr,
   output logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // Status
   output logic [7:0] baud_rate_divider,
   output logic       line_signal_enable
);
   // Bit period in reference ticks, split into 16 oversample ticks below
   function automatic logic [16:0] bit_ref_ticks(input logic [7:0] div);
      logic [2:0]  e;
      logic [16:0] m;
      e = div[`UHRP_EXP_MSB:`UHRP_EXP_LSB];
      m = {12'h000, div[`UHRP_MAN_MSB:`UHRP_MAN_LSB]};
      if (e == 3'h0) begin
         bit_ref_ticks = m + 17'h00001;
      end else begin
         bit_ref_ticks = (m + `UHRP_MAN_OFFSET) << (e - 3'h1);
      end
   endfunction

   // Local register and rate
   logic [7:0]  testpin;
   logic [16:0] period;

   // Receive side
   logic        rx_s1;
   logic        rx_s2;
   logic        rx_d;
   logic [3:0]  rx_os;
   logic [3:0]  rx_bit;
   logic        rx_busy;
   logic [7:0]  rx_sh;
   logic        rx_done;
   logic [7:0]  rx_byte;

   // Transmit side
   logic [3:0]  tx_os;
   logic [3:0]  tx_bit;
   logic        tx_busy;
   logic [9:0]  tx_sh;

   // Transmit queue
   logic        f_in_valid;
   logic [7:0]  f_in_data;
   logic        f_in_ready;
   logic        f_out_valid;
   logic        f_out_ready;
   logic [7:0]  f_out_data;

   // Command handling
   uhrp_state_t state;
   uhrp_cmd_t   cmd;
   logic [7:0]  rd_val;

   assign line_signal_enable = testpin[`UHRP_LINE_EN_BIT];
   // Bit period in reference ticks
   assign period = bit_ref_ticks(baud_rate_divider);

   // Fractional rate generator, wide enough for the slowest divider
   logic [39:0] frac;
   logic        os_tick;
   logic [39:0] frac_lim;

   assign frac_lim = 40'(period) * 40'(`UHRP_CLK_HZ / `UHRP_OVS);
   assign os_tick  = (frac + 40'(`UHRP_REF_HZ) >= frac_lim);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         frac <= '0;
      end else if (os_tick) begin
         frac <= frac + 40'(`UHRP_REF_HZ) - frac_lim;
      end else begin
         frac <= frac + 40'(`UHRP_REF_HZ);
      end
   end

   // Input synchroniser
   always_ff @(posedge clk_sys) begin
      rx_s1 <= rx;
      rx_s2 <= rx_s1;
      rx_d  <= rx_s2;
   end

   // Receiver
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_busy <= 1'b0;
         rx_os   <= 4'h0;
         rx_bit  <= 4'h0;
         rx_done <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (rx_d && !rx_s2) begin
               rx_busy <= 1'b1;
               rx_os   <= 4'h0;
               rx_bit  <= 4'h0;
            end
         end else if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UHRP_OVS_HALF) begin
               if (rx_bit == 4'h0) begin
                  if (rx_s2) begin
                     rx_busy <= 1'b0;
                  end
               end else if (rx_bit == `UHRP_BITS_LAST) begin
                  rx_busy <= 1'b0;
                  if (rx_s2) begin
                     rx_done <= 1'b1;
                     rx_byte <= rx_sh;
                  end
               end
               rx_bit <= rx_bit + 4'h1;
            end
         end
      end
   end

   // Receive shift register, data bits only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_sh <= 8'h00;
      end else if (rx_busy && os_tick && (rx_os == `UHRP_OVS_HALF)
                   && (rx_bit != 4'h0) && (rx_bit != `UHRP_BITS_LAST)) begin
         rx_sh <= {rx_s2, rx_sh[7:1]};
      end
   end

   // Command byte capture
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd <= '0;
      end else if ((state == UHRP_IDLE) && rx_done) begin
         cmd <= rx_byte;
      end
   end

   // Command engine
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= UHRP_IDLE;
      end else begin
         case (state)
            UHRP_IDLE: begin
               if (rx_done) begin
                  if (rx_byte[`UHRP_CMD_READ_BIT]) begin
                     state <= UHRP_RESP;
                  end else begin
                     state <= UHRP_WDAT;
                  end
               end
            end
            UHRP_WDAT: begin
               if (rx_done) begin
                  state <= UHRP_IDLE;
               end
            end
            UHRP_RESP: begin
               state <= UHRP_IDLE;
            end
            default: begin
               state <= UHRP_IDLE;
            end
         endcase
      end
   end

   assign reg_rd    = (state == UHRP_RESP);
   assign reg_wr    = (state == UHRP_WDAT) && rx_done;
   assign reg_addr  = cmd.addr;
   assign reg_wdata = rx_byte;

   // Divider register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         baud_rate_divider <= `UHRP_BAUD_RESET;
      end else if (reg_wr && (cmd.addr == `UHRP_ADDR_BAUD)) begin
         baud_rate_divider <= rx_byte;
      end
   end

   // Test pin control register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         testpin <= `UHRP_TESTPIN_RESET;
      end else if (reg_wr && (cmd.addr == `UHRP_ADDR_TESTPIN)) begin
         testpin <= rx_byte;
      end
   end

   always_comb begin
      case (cmd.addr)
         `UHRP_ADDR_BAUD:    rd_val = baud_rate_divider;
         `UHRP_ADDR_TESTPIN: rd_val = testpin;
         default:            rd_val = reg_rdata;
      endcase
   end

   // Transmit queue: read data or echoed write command
   assign f_in_valid = reg_rd || ((state == UHRP_IDLE) && rx_done && !rx_byte[`UHRP_CMD_READ_BIT]);
   assign f_in_data  = reg_rd ? rd_val : rx_byte;
   assign f_out_ready = !tx_busy;

   uhrp_fifo #(.WIDTH(8), .DEPTH(`UHRP_FIFO_DEPTH)) u_fifo (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .in_valid (f_in_valid),
      .in_ready (f_in_ready),
      .in_data  (f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data (f_out_data)
   );

   // Transmitter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_busy <= 1'b0;
         tx_sh   <= 10'h3FF;
         tx_os   <= 4'h0;
         tx_bit  <= 4'h0;
         tx      <= 1'b1;
      end else if (!tx_busy) begin
         tx <= 1'b1;
         if (f_out_valid) begin
            tx_busy <= 1'b1;
            tx_sh   <= {1'b1, f_out_data, 1'b0};
            tx_os   <= 4'h0;
            tx_bit  <= 4'h0;
         end
      end else begin
         tx <= tx_sh[0];
         if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `UHRP_OVS_LAST) begin
               tx_sh  <= {1'b1, tx_sh[9:1]};
               tx_bit <= tx_bit + 4'h1;
               if (tx_bit == `UHRP_BITS_LAST) tx_busy <= 1'b0;
            end
         end
      end
   end

   // Data request line follows the device event
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_request_line <= 1'b0;
      end else begin
         data_request_line <= data_request_in;
      end
   end

   // Multiplex line marks a frame in flight
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         multiplex_line <= 1'b0;
      end else begin
         multiplex_line <= tx_busy;
      end
   end

   assign data_request_line_oe_n = !line_signal_enable;
   assign multiplex_line_oe_n    = !line_signal_enable;
endmodule

// ### tb/uhrp_top_properties.sv
// Purpose: port checks of the serial host port
// Assumes: top module ports only
// Notes:   bound at the foot
`timescale 1ns/1ps
module uhrp_checker (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // Watched outputs
   input wire logic       tx,
   input wire logic       multiplex_line,
   input wire logic       data_request_line_oe_n,
   input wire logic       multiplex_line_oe_n,
   input wire logic       reg_rd,
   input wire logic       reg_wr,
   input wire logic [7:0] baud_rate_divider,
   input wire logic       line_signal_enable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   reset_state_a: assert property ($past(rst) |-> tx && baud_rate_divider == 8'hEB && line_signal_enable)
      else $error("bad state after reset");
   rd_pulse_a: assert property (reg_rd |=> !reg_rd)
      else $error("read strobe too long");
   wr_pulse_a: assert property (reg_wr |=> !reg_wr)
      else $error("write strobe too long");
   rd_wr_excl_a: assert property (!(reg_rd && reg_wr))
      else $error("read and write together");
   oe_gate_a: assert property (data_request_line_oe_n == !line_signal_enable
      && multiplex_line_oe_n == !line_signal_enable)
      else $error("line enables wrong");
   reply_start_a: assert property (reg_rd && tx && !multiplex_line |-> ##[1:4] !tx)
      else $error("no reply start");
   mux_busy_a: assert property (line_signal_enable && !tx && $past(!tx) |-> multiplex_line)
      else $error("mux low while sending");
   start_len_a: assert property ($fell(tx) |-> !tx [*8])
      else $error("start bit short");
endmodule
bind uhrp_top uhrp_checker u_chk (.clk_sys, .rst, .tx, .multiplex_line, .data_request_line_oe_n,
   .multiplex_line_oe_n, .reg_rd, .reg_wr, .baud_rate_divider, .line_signal_enable);

// ### tb/uhrp_host.sv
// Purpose: host side serial model
// Assumes: line idles high
// Notes:   bit time set by the bench
`timescale 1ns/1ps
module uhrp_host (
   // Serial link
   output logic      rx,
   input  wire logic tx
);
   // Default 9600 Bd until the bench sets bit_ns
   real bit_ns = 1.0e9 / 9600.0;
   initial rx = 1'b1;
   task automatic send(input logic [7:0] b, input logic stop);
      rx = 1'b0;
      #(bit_ns);
      for (int i = 0; i < 8; i++) begin
         rx = b[i];
         #(bit_ns);
      end
      rx = stop;
      #(bit_ns);
      rx = 1'b1;
   endtask
   task automatic recv(output logic [7:0] b);
      @(negedge tx);
      #(1.5 * bit_ns);
      for (int i = 0; i < 8; i++) begin
         b[i] = tx;
         #(bit_ns);
      end
   endtask
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench of the serial host port
// Assumes: host model on the serial pins
// Notes:   rate moves to 7Ah early to keep the run short
`timescale 1ns/1ps
module tb;
   import uhrp_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic       data_request_in = 1'b0;
   logic [7:0] reg_rdata = 8'hA5;
   logic       rx, tx, data_request_line, data_request_line_oe_n, multiplex_line, multiplex_line_oe_n;
   logic       reg_rd, reg_wr, line_signal_enable;
   logic [5:0] reg_addr, ra;
   logic [7:0] reg_wdata, baud_rate_divider, wd;
   int         failures = 0;
   int         n_checks = 0;
   int         nrd = 0;
   int         nb;
   real        t0, t1, w;
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (reg_rd) begin
         nrd <= nrd + 1;
         ra  <= reg_addr;
      end
      if (reg_wr) wd <= reg_wdata;
   end
   always @(negedge tx) t0 = $realtime;
   always @(posedge tx) w = $realtime - t0;
   uhrp_top DUT (.clk_sys, .rst, .rx, .tx, .data_request_line, .data_request_line_oe_n, .multiplex_line,
      .multiplex_line_oe_n, .data_request_in, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .baud_rate_divider, .line_signal_enable);
   uhrp_host host (.rx, .tx);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] e;
      fork
         begin
            host.send(c, 1'b1);
            host.send(d, 1'b1);
         end
         host.recv(e);
      join
      chk(e, c);
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] x);
      logic [7:0] e;
      fork
         host.send(c, 1'b1);
         host.recv(e);
      join
      chk(e, x);
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #4ms;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      chk(baud_rate_divider, 8'hEB);
      chk({4'h0, tx, line_signal_enable, data_request_line_oe_n, multiplex_line_oe_n}, 8'h0C);
      wr(8'h00, 8'h7A);
      chk(baud_rate_divider, 8'h7A);
      host.bit_ns = 4.0 * 59.0 * 1.0e9 / 27.12e6;
      rd(8'h80, 8'h7A);
      rd(8'hC0, 8'h7A);
      rd(8'h85, 8'hA5);
      chk({2'b00, ra}, 8'h05);
      chk({7'h00, w > 0.96 * host.bit_ns && w < 1.04 * host.bit_ns}, 8'h01);
      wr(8'h05, 8'h96);
      chk(wd, 8'h96);
      @(negedge clk_sys);
      data_request_in = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk({7'h00, data_request_line}, 8'h01);
      wr(8'h01, 8'h00);
      chk({5'h00, line_signal_enable, data_request_line_oe_n, multiplex_line_oe_n}, 8'h03);
      wr(8'h01, 8'h80);
      nb = nrd;
      t1 = t0;
      host.send(8'h80, 1'b0);
      #(3.0 * host.bit_ns);
      chk({7'h00, nrd == nb && t0 == t1}, 8'h01);
      rd(8'h81, 8'h80);
      tally_and_finish();
   end
endmodule
